/* File: pkg/gcsr_defines.vh */
`ifndef GCSR_DEFINES_VH
`define GCSR_DEFINES_VH
// register offsets (byte addresses)
`define GCSR_ADDR_DRIVE 16'h010D
`define GCSR_ADDR_IBSTAT 16'h0110
`define GCSR_ADDR_OVR 16'h0120
`define GCSR_ADDR_LVL 16'h0124
`define GCSR_ADDR_IBCTRL 16'h0104
`define GCSR_ADDR_IRQST 16'h0204
`define GCSR_ADDR_IRQMSK 16'h0208
// drive strength fields
`define GCSR_DRV_RESET 8'h62
`define GCSR_DRV_HS_MSB 6
`define GCSR_DRV_HS_LSB 4
`define GCSR_DRV_LS_MSB 2
`define GCSR_DRV_LS_LSB 0
// in-band status bits
`define GCSR_ST_GOOD 31
`define GCSR_ST_RESP 30
`define GCSR_ST_EXEC 29
`define GCSR_ST_MAC 14
`define GCSR_ST_FMT 13
`define GCSR_ST_CODE 12
`define GCSR_ST_CMD 11
`define GCSR_ST_SIZE 10
`define GCSR_ST_LOC_MSB 6
`define GCSR_TAG_CLR_MASK 32'h60007C00
// frame checks
`define GCSR_ACCESS_FORMAT 16'h9800
`define GCSR_ACCESS_CODE_A 16'h0001
`define GCSR_ACCESS_CODE_B 16'h0002
`define GCSR_MAX_FRAME_BYTES 10'h140
// control register, pin count and event count
`define GCSR_CTRL_DA_CHECK 30
`define GCSR_CTRL_RESTART 29
`define GCSR_CTRL_RESET 32'h004640FE
`define GCSR_CTRL_WMASK 32'hE0C7FFFF
`define GCSR_PINS 10
`define GCSR_NEV 8
`endif

/* File: src/gcsr_frame_eval.v */
`timescale 1ns/1ps
`include "gcsr_defines.vh"
// classifies one frame-summary strobe into status set/clear masks
module gcsr_frame_eval (
	input wire i_frame_valid,
	input wire i_da_check_en,
	input wire i_da_match,
	input wire [15:0] i_access_format,
	input wire [15:0] i_access_code,
	input wire i_cmd_unknown,
	input wire [9:0] i_frame_bytes,
	output reg [31:0] o_set_mask,
	output reg o_tag_clear,
	output reg o_discard
);
	always @* begin
		o_set_mask = 32'h00000000;
		o_tag_clear = 1'b0;
		o_discard = 1'b0;
		if (i_frame_valid) begin
			o_tag_clear = 1'b1;
			if (i_da_check_en && !i_da_match) begin
				o_set_mask[`GCSR_ST_MAC] = 1'b1;
				o_discard = 1'b1;
			end
			if (i_access_format != `GCSR_ACCESS_FORMAT)
				o_set_mask[`GCSR_ST_FMT] = 1'b1;
			if (i_access_code != `GCSR_ACCESS_CODE_A && i_access_code != `GCSR_ACCESS_CODE_B)
				o_set_mask[`GCSR_ST_CODE] = 1'b1;
			if (i_cmd_unknown)
				o_set_mask[`GCSR_ST_CMD] = 1'b1;
			if (i_frame_bytes > `GCSR_MAX_FRAME_BYTES)
				o_set_mask[`GCSR_ST_SIZE] = 1'b1;
			if (o_set_mask == 32'h00000000)
				o_set_mask[`GCSR_ST_GOOD] = 1'b1;
		end
	end
endmodule

/* File: src/gcsr_top.v */
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
`include "gcsr_defines.vh"
module gcsr_top (
	input wire I_CLK,
	input wire I_RESET_N,
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [15:0] WB_ADR_I,
	input wire [31:0] WB_DAT_I,
	input wire [3:0] WB_SEL_I,
	output reg [31:0] WB_DAT_O,
	output reg WB_ACK_O,
	input wire i_frame_valid,
	input wire i_tag_match,
	input wire i_da_match,
	input wire [15:0] i_access_format,
	input wire [15:0] i_access_code,
	input wire i_cmd_unknown,
	input wire [6:0] i_cmd_location,
	input wire [9:0] i_frame_bytes,
	input wire i_resp_sent,
	input wire i_exec_done,
	input wire [9:0] i_indicator_func,
	output reg [9:0] o_indicator_pin,
	output wire [2:0] o_hs_drive,
	output wire [2:0] o_ls_drive,
	output wire o_dest_addr_check_enable,
	output wire o_frame_discard,
	output wire o_resp_suppress,
	output wire o_irq
);
	reg [7:0] drive_reg;
	reg [31:0] status_reg;
	reg [31:0] status_next;
	reg [9:0] override_reg;
	reg [9:0] level_reg;
	reg [31:0] ctrl_reg;
	reg [7:0] irq_st_reg;
	reg [7:0] irq_st_next;
	reg [7:0] irq_mask_reg;
	wire [31:0] set_mask;
	wire tag_clear;
	wire discard;
	wire access;
	wire wr;
	wire rd;
	wire [7:0] events;
	reg [31:0] rd_data;
	integer k;
	wire hit_drive;
	wire hit_status;
	wire hit_ovr;
	wire hit_lvl;
	wire hit_ctrl;
	wire hit_irqst;
	wire hit_mask;
	wire [31:0] word_drive;
	wire [31:0] word_ovr;
	wire [31:0] word_lvl;
	wire [31:0] word_irqst;
	wire [31:0] word_mask;
	wire [31:0] ctrl_wmask;
	wire [31:0] ctrl_wdata;
	wire ev_oversize;
	wire ev_cmd_err;
	wire ev_access_err;
	wire ev_mac_err;
	wire ev_exec;
	wire ev_resp;
	wire ev_good;

	assign access = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	assign wr = access & WB_WE_I;
	assign rd = access & ~WB_WE_I;

	// one hit line per register keeps the write blocks independent
	assign hit_drive = (WB_ADR_I == `GCSR_ADDR_DRIVE);
	assign hit_status = (WB_ADR_I == `GCSR_ADDR_IBSTAT);
	assign hit_ovr = (WB_ADR_I == `GCSR_ADDR_OVR);
	assign hit_lvl = (WB_ADR_I == `GCSR_ADDR_LVL);
	assign hit_ctrl = (WB_ADR_I == `GCSR_ADDR_IBCTRL);
	assign hit_irqst = (WB_ADR_I == `GCSR_ADDR_IRQST);
	assign hit_mask = (WB_ADR_I == `GCSR_ADDR_IRQMSK);

	gcsr_frame_eval u_eval (
		.i_frame_valid(i_frame_valid),
		.i_da_check_en(ctrl_reg[`GCSR_CTRL_DA_CHECK]),
		.i_da_match(i_da_match),
		.i_access_format(i_access_format),
		.i_access_code(i_access_code),
		.i_cmd_unknown(i_cmd_unknown),
		.i_frame_bytes(i_frame_bytes),
		.o_set_mask(set_mask),
		.o_tag_clear(tag_clear),
		.o_discard(discard)
	);

	assign o_frame_discard = discard;
	assign o_resp_suppress = set_mask[`GCSR_ST_SIZE];
	assign o_dest_addr_check_enable = ctrl_reg[`GCSR_CTRL_DA_CHECK];
	assign o_hs_drive = drive_reg[`GCSR_DRV_HS_MSB:`GCSR_DRV_HS_LSB];
	assign o_ls_drive = drive_reg[`GCSR_DRV_LS_MSB:`GCSR_DRV_LS_LSB];

	// status update: clear by matching tag first, then new sets win
	always @* begin
		status_next = status_reg;
		if (tag_clear && i_tag_match)
			status_next = status_next & ~`GCSR_TAG_CLR_MASK;
		status_next = status_next | set_mask;
		if (i_resp_sent)
			status_next[`GCSR_ST_RESP] = 1'b1;
		if (i_exec_done)
			status_next[`GCSR_ST_EXEC] = 1'b1;
		if (set_mask[`GCSR_ST_CMD])
			status_next[`GCSR_ST_LOC_MSB:0] = i_cmd_location;
		else if (!status_next[`GCSR_ST_CMD])
			status_next[`GCSR_ST_LOC_MSB:0] = 7'h00;
		status_next[28:15] = 14'h0000;
		status_next[9:7] = 3'h0;
	end

	// format and code errors share one bit so the events fit a byte
	assign ev_oversize = set_mask[`GCSR_ST_SIZE];
	assign ev_cmd_err = set_mask[`GCSR_ST_CMD];
	assign ev_access_err = set_mask[`GCSR_ST_FMT] | set_mask[`GCSR_ST_CODE];
	assign ev_mac_err = set_mask[`GCSR_ST_MAC];
	assign ev_exec = i_exec_done;
	assign ev_resp = i_resp_sent;
	assign ev_good = set_mask[`GCSR_ST_GOOD];
	assign events = {1'b0, ev_good, ev_resp, ev_exec, ev_mac_err, ev_access_err, ev_cmd_err, ev_oversize};

	// read of interrupt status clears it, but a same-cycle event still lands
	genvar b;
	generate
		for (b = 0; b < `GCSR_NEV; b = b + 1) begin : g_irq
			always @* begin
				irq_st_next[b] = irq_st_reg[b];
				if (rd && hit_irqst)
					irq_st_next[b] = 1'b0;
				if (events[b])
					irq_st_next[b] = 1'b1;
			end
		end
	endgenerate

	assign o_irq = |(irq_st_reg & irq_mask_reg);

	// registers sit in the low bits, the rest reads zero
	assign word_drive = {24'h000000, drive_reg};
	assign word_ovr = {22'h000000, override_reg};
	assign word_lvl = {22'h000000, level_reg};
	assign word_irqst = {24'h000000, irq_st_reg};
	assign word_mask = {24'h000000, irq_mask_reg};

	// status read-only at its offset
	// unmapped addresses fall through to zero
	always @* begin
		rd_data = 32'h00000000;
		if (hit_drive)
			rd_data = word_drive;
		if (hit_status)
			rd_data = status_reg;
		if (hit_ovr)
			rd_data = word_ovr;
		if (hit_lvl)
			rd_data = word_lvl;
		if (hit_ctrl)
			rd_data = ctrl_reg;
		if (hit_irqst)
			rd_data = word_irqst;
		if (hit_mask)
			rd_data = word_mask;
	end

	// ack lasts one cycle because access needs ack low
	always @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			WB_ACK_O <= 1'b0;
		end else begin
			WB_ACK_O <= access;
		end
	end

	// read data stays until the next read, writes leave it alone
	always @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			WB_DAT_O <= 32'h00000000;
		end else if (rd) begin
			WB_DAT_O <= rd_data;
		end
	end

	// sticky flags follow their next values every cycle
	always @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			status_reg <= 32'h00000000;
			irq_st_reg <= 8'h00;
		end else begin
			status_reg <= status_next;
			irq_st_reg <= irq_st_next;
		end
	end

	// reserved RW bits 7 and 3 stored with the codes
	always @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			drive_reg <= `GCSR_DRV_RESET;
		end else if (wr && hit_drive && WB_SEL_I[0]) begin
			drive_reg <= WB_DAT_I[7:0];
		end
	end

	// override bits over two byte lanes
	always @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			override_reg <= 10'h000;
		end else if (wr && hit_ovr) begin
			if (WB_SEL_I[0])
				override_reg[7:0] <= WB_DAT_I[7:0];
			if (WB_SEL_I[1])
				override_reg[9:8] <= WB_DAT_I[9:8];
		end
	end

	// output levels over two byte lanes
	always @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			level_reg <= 10'h000;
		end else if (wr && hit_lvl) begin
			if (WB_SEL_I[0])
				level_reg[7:0] <= WB_DAT_I[7:0];
			if (WB_SEL_I[1])
				level_reg[9:8] <= WB_DAT_I[9:8];
		end
	end

	// control register; read-only fields never take a write
	assign ctrl_wmask = `GCSR_CTRL_WMASK;
	assign ctrl_wdata = (WB_DAT_I & ctrl_wmask) | (ctrl_reg & ~ctrl_wmask);

	always @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			ctrl_reg <= `GCSR_CTRL_RESET;
		end else begin
			// restart bit is a one-cycle request, so it clears itself
			ctrl_reg[`GCSR_CTRL_RESTART] <= 1'b0;
			if (wr && hit_ctrl) begin
				for (k = 0; k < 4; k = k + 1)
					if (WB_SEL_I[k])
						ctrl_reg[k*8 +: 8] <= ctrl_wdata[k*8 +: 8];
			end
		end
	end

	// interrupt mask, same layout as the interrupt status
	always @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			irq_mask_reg <= 8'h00;
		end else if (wr && hit_mask && WB_SEL_I[0]) begin
			irq_mask_reg <= WB_DAT_I[7:0];
		end
	end

	// bit n drives pin n, ordered port1 pin0, port1 pin1, ...
	genvar g;
	generate
		for (g = 0; g < `GCSR_PINS; g = g + 1) begin : g_pin
			always @(posedge I_CLK or negedge I_RESET_N) begin
				if (!I_RESET_N)
					o_indicator_pin[g] <= 1'b0;
				else
					o_indicator_pin[g] <= override_reg[g] ? level_reg[g] : i_indicator_func[g];
			end
		end
	endgenerate
endmodule

/* File: tb/gcsr_chk.sv */
`timescale 1ns/1ps
module gcsr_chk (
	input wire I_CLK,
	input wire I_RESET_N,
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [15:0] WB_ADR_I,
	input wire [31:0] WB_DAT_O,
	input wire WB_ACK_O,
	input wire i_frame_valid,
	input wire i_da_match,
	input wire [9:0] i_frame_bytes,
	input wire o_dest_addr_check_enable,
	input wire o_frame_discard,
	input wire o_resp_suppress
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RESET_N);
	chk_ack_follows: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("request not acknowledged");
	chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held too long");
	chk_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I) && $past(WB_STB_I))
		else $error("ack without request");
	chk_discard_mac: assert property (o_frame_discard == (i_frame_valid && o_dest_addr_check_enable && !i_da_match))
		else $error("discard wrong");
	chk_oversize_sup: assert property (o_resp_suppress == (i_frame_valid && i_frame_bytes > 10'h140))
		else $error("response suppress wrong");
	chk_status_resv: assert property (WB_ACK_O && $past(WB_ADR_I) == 16'h0110 && !$past(WB_WE_I) |->
		WB_DAT_O[28:15] == 14'h0 && WB_DAT_O[9:7] == 3'h0) else $error("status reserved bits set");
	chk_loc_zero: assert property (WB_ACK_O && $past(WB_ADR_I) == 16'h0110 && !$past(WB_WE_I) && !WB_DAT_O[11] |->
		WB_DAT_O[6:0] == 7'h00) else $error("location without command error");
	chk_pin_resv: assert property (WB_ACK_O && !$past(WB_WE_I) && $past(WB_ADR_I[15:3]) == 13'h0024 |->
		WB_DAT_O[31:10] == 22'h0) else $error("pin register reserved bits set");
endmodule
bind gcsr_top gcsr_chk u_chk (.I_CLK, .I_RESET_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_O,
	.WB_ACK_O, .i_frame_valid, .i_da_match, .i_frame_bytes, .o_dest_addr_check_enable, .o_frame_discard,
	.o_resp_suppress);

/* File: tb/gcsr_tb.sv */
`timescale 1ns/1ps
module testbench;
	reg I_CLK = 0, I_RESET_N = 0, cyc = 0, we = 0, fv = 0, tag = 0, dam = 0, unk = 0, rs = 0, ed = 0;
	reg [15:0] adr = 0, fmt = 0, code = 0;
	reg [31:0] wd = 0, rd = 0;
	reg [9:0] nb = 0, func = 0;
	reg da_on = 0;
	wire disc, sup;
	integer error_cnt = 0, samples_checked = 0, n;
	wire [31:0] dato;
	wire ack, irq, dce;
	wire [9:0] pin;
	wire [2:0] hs, ls;
	always #10 I_CLK = ~I_CLK;
	gcsr_top dut (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_DAT_I(wd), .WB_SEL_I(4'hF), .WB_DAT_O(dato), .WB_ACK_O(ack), .i_frame_valid(fv),
		.i_tag_match(tag), .i_da_match(dam), .i_access_format(fmt), .i_access_code(code), .i_cmd_unknown(unk),
		.i_cmd_location(7'h05), .i_frame_bytes(nb), .i_resp_sent(rs), .i_exec_done(ed), .i_indicator_func(func),
		.o_indicator_pin(pin), .o_hs_drive(hs), .o_ls_drive(ls), .o_dest_addr_check_enable(dce),
		.o_frame_discard(disc), .o_resp_suppress(sup), .o_irq(irq));
	task stop_test;
		begin
			$display("checks %0d mismatches %0d", samples_checked, error_cnt);
			if (error_cnt == 0 && samples_checked > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task chk(input [127:0] nm, input [31:0] e, input [31:0] g);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				error_cnt = error_cnt + 1;
				$display("wrong value %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// ack is sampled as it stood before each edge; release only after it
	task wb(input w, input [15:0] a, input [31:0] d);
		begin
			@(posedge I_CLK);
			cyc <= 1;
			we <= w;
			adr <= a;
			wd <= d;
			n = 0;
			do begin
				@(posedge I_CLK);
				n = n + 1;
			end while (ack !== 1'b1 && n < 20);
			rd = dato;
			cyc <= 0;
			we <= 0;
			if (n >= 20) begin
				chk("ack", 1, 0);
				stop_test;
			end
		end
	endtask
	task frame(input t, input d, input [15:0] f, input [15:0] c, input u, input [9:0] b);
		begin
			@(posedge I_CLK);
			fv <= 1;
			tag <= t;
			dam <= d;
			fmt <= f;
			code <= c;
			unk <= u;
			nb <= b;
			@(posedge I_CLK);
			chk("discard", da_on & ~d, disc);
			chk("suppress", b > 10'h140, sup);
			fv <= 0;
		end
	endtask
	task t_reset;
		begin
			wb(0, 16'h010D, 0);
			chk("drive", 32'h62, rd);
			wb(0, 16'h0104, 0);
			chk("ctrl", 32'h004640FE, rd);
			chk("hs", 3'h6, hs);
			chk("ls", 3'h2, ls);
			wb(1, 16'h0110, 32'hFFFFFFFF);
			wb(0, 16'h0110, 0);
			chk("status", 0, rd);
			wb(0, 16'h0124, 0);
			chk("level", 0, rd);
			$display("reset test done");
		end
	endtask
	task t_pins;
		begin
			func <= 10'h2AA;
			wb(1, 16'h0120, 32'hFFFFFC55);
			wb(1, 16'h0124, 32'h000003F0);
			wb(0, 16'h0120, 0);
			chk("override", 32'h55, rd);
			chk("pins", 10'h2FA, pin);
			$display("pin test done");
		end
	endtask
	task t_frames;
		begin
			frame(0, 0, 16'h9800, 16'h0001, 0, 10'd320);
			wb(0, 16'h0110, 0);
			chk("good", 32'h80000000, rd);
			rs <= 1;
			ed <= 1;
			@(posedge I_CLK);
			rs <= 0;
			ed <= 0;
			wb(0, 16'h0110, 0);
			chk("done", 32'hE0000000, rd);
			wb(1, 16'h0104, 32'h40000000);
			da_on = 1;
			chk("check on", 1, dce);
			frame(1, 0, 16'h9800, 16'h0002, 0, 10'd64);
			wb(0, 16'h0110, 0);
			chk("mac", 32'h80004000, rd);
			frame(1, 1, 16'h9801, 16'h0003, 1, 10'd321);
			wb(0, 16'h0110, 0);
			chk("errors", 32'h80003C05, rd);
			frame(1, 1, 16'h9800, 16'h0002, 0, 10'd64);
			wb(0, 16'h0110, 0);
			chk("cleared", 32'h80000000, rd);
			$display("frame test done");
		end
	endtask
	task t_irq;
		begin
			chk("irq masked", 0, irq);
			wb(1, 16'h0208, 32'h000000FF);
			chk("irq on", 1, irq);
			wb(0, 16'h0204, 0);
			chk("events", 32'h7F, rd);
			wb(0, 16'h0204, 0);
			chk("events cleared", 0, rd);
			chk("irq off", 0, irq);
			wb(0, 16'h0300, 0);
			chk("unmapped", 0, rd);
			$display("irq test done");
		end
	endtask
	initial begin
		repeat (20) @(posedge I_CLK);
		I_RESET_N <= 1;
		t_reset;
		t_pins;
		t_frames;
		t_irq;
		stop_test;
	end
endmodule
